// [hw/ipc_pkg.sv]
// constants, commands and carrier types of the interrupt pending control block
package ipc_pkg;

  // ----------------------------------------------------------------
  // clocking and scheduled timer base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SCHED_UNIT_NS = 100_000; // 0.1 ms
  // a whole unit, rounded up to cycles
  localparam int unsigned SCHED_UNIT_CYCLES =
    (SCHED_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] TICK_LAST = 12'(SCHED_UNIT_CYCLES - 1);

  // ----------------------------------------------------------------
  // selector values and control words
  // ----------------------------------------------------------------
  localparam logic [15:0] SEL_SCHED = 16'h0004;
  localparam logic [15:0] SEL_HSC_FIRST = 16'h000a;
  localparam logic [15:0] SEL_HSC_LAST = 16'h000f;
  localparam logic [15:0] SEL_IO_FIRST = 16'h0066;
  localparam logic [15:0] SEL_IO_LAST = 16'h006b;
  localparam logic [15:0] CTRL_RETAIN = 16'h0000;
  localparam logic [15:0] CTRL_CLEAR = 16'h0001;
  localparam logic [15:0] CTRL_UNMASK = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'h0001;
  localparam logic [15:0] SCHED_STOP = 16'h0000;
  localparam logic [15:0] SCHED_MIN = 16'h000a;
  localparam logic [15:0] SCHED_MAX = 16'h270f;

  // ----------------------------------------------------------------
  // task numbers and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] TASK_SCHED = 4'h1;
  localparam logic [3:0] TASK_IO_BASE = 4'h2;
  localparam logic [3:0] TASK_HSC_BASE = 4'h8;
  localparam logic [3:0] TASK_POWER_OFF = 4'hf;
  localparam logic [5:0] IO_MASK_RESET = 6'h3f;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_PENDING_CLEAR = 3'b001,
    OP_MASK_SET = 3'b010,
    OP_BLOCK = 3'b011,
    OP_UNBLOCK = 3'b100
  } ipc_op_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } ipc_state_t;

  typedef struct packed {
    logic valid;
    ipc_op_t op;
    logic [15:0] selector;
    logic [15:0] control;
  } ipc_cmd_t;

  typedef struct packed {
    logic start;
    logic [3:0] id;
  } ipc_task_t;

  typedef struct packed {
    logic [5:0] io_pending;
    logic [5:0] io_mask;
    logic [5:0] hsc_pending;
    logic sched_pending;
    logic sched_running;
    logic blocked;
    logic in_task;
  } ipc_status_t;

endpackage : ipc_pkg

// [hw/ipc_top.sv]
// interrupt pending control: records, clears and dispatches interrupts
//
// What this block does
// - selectors 102..107 address io inputs 2..7, task of same number.
// - io control 0000 hex retains the pending record, 0001 hex clears it.
// - selector 4 addresses scheduled timer 0, which triggers task 1.
// - scheduled control 10..9999 in 0.1 ms units sets time to first tick.
// - selectors 10..15 address counter comparison records 0..5.
// - counter control 0001 hex clears the record, 0000 hex retains it.
// - error flag set when a clear or mask set selector is not a defined value.
// - error flag set when io or counter control is not 0000 or 0001.
// - error flag set for scheduled value outside 10..9999 (0 allowed in mask set, stops timer); cleared if valid.
// - io clear or retain follows the control bit: set clears.
// - io interrupts arriving during a running task are latched pending.
// - pending io interrupts served later, lowest number first.
// - global block stops io and scheduled tasks, never power-off.
// - after a block, tasks stay blocked until global unblock.
// - block issued inside an interrupt task is rejected with error.
// - unmasking an io input discards earlier detections on it.
// - at start all io inputs masked and scheduled timer stopped.
`timescale 1ns/1ps
module ipc_top
  import ipc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire ipc_cmd_t cmd,
  input wire logic [5:0] io_irq_pin,
  input wire logic [5:0] hsc_match_pin,
  input wire logic power_off_pin,
  input wire logic task_done,
  output logic instruction_error_flag,
  output logic cmd_ack,
  output ipc_task_t task_start,
  output ipc_status_t status
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic [12:0] sync3;
  logic [5:0] edge_io;
  logic [5:0] edge_hsc;
  logic edge_pwr;
  // sync1 feeds sync2 only; edges are taken from sync2 against sync3
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {power_off_pin, hsc_match_pin, io_irq_pin};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign edge_io = sync2[5:0] & ~sync3[5:0];
  assign edge_hsc = sync2[11:6] & ~sync3[11:6];
  assign edge_pwr = sync2[12] & ~sync3[12];

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [5:0] io_pending, next_io_pending;
  logic [5:0] io_mask, next_io_mask;
  logic [5:0] hsc_pending, next_hsc_pending;
  logic blocked, next_blocked;
  ipc_state_t state, next_state;
  logic in_task;
  logic is_io, is_hsc, is_sched, ctl01, sched_ok, cmd_err;
  logic [2:0] idx;
  logic clr_ok, msk_ok;
  assign in_task = (state == ST_RUN);
  // selector windows; idx is the input or counter number
  assign is_io = cmd.selector >= SEL_IO_FIRST
              && cmd.selector <= SEL_IO_LAST;
  assign is_hsc = cmd.selector >= SEL_HSC_FIRST
               && cmd.selector <= SEL_HSC_LAST;
  assign is_sched = cmd.selector == SEL_SCHED;
  assign idx = is_io ? 3'(cmd.selector - SEL_IO_FIRST)
                     : 3'(cmd.selector - SEL_HSC_FIRST);
  assign ctl01 = cmd.control == CTRL_RETAIN || cmd.control == CTRL_CLEAR;
  assign sched_ok = cmd.control >= SCHED_MIN && cmd.control <= SCHED_MAX;
  // operand checks per operation
  always_comb begin
    case (cmd.op)
      OP_PENDING_CLEAR: cmd_err = !(is_io || is_hsc || is_sched)
        || ((is_io || is_hsc) && !ctl01)
        || (is_sched && !sched_ok);
      OP_MASK_SET: cmd_err = !(is_io || is_sched)
        || (is_io && !ctl01)
        || (is_sched && !(sched_ok || cmd.control == SCHED_STOP));
      OP_BLOCK: cmd_err = in_task;
      OP_UNBLOCK: cmd_err = in_task;
      default: cmd_err = 1'b1;
    endcase
  end
  assign clr_ok = cmd.valid && cmd.op == OP_PENDING_CLEAR && !cmd_err;
  assign msk_ok = cmd.valid && cmd.op == OP_MASK_SET && !cmd_err;

  // ----------------------------------------------------------------
  // scheduled timer
  // ----------------------------------------------------------------
  logic sched_running, next_sched_running;
  logic sched_pending, next_sched_pending;
  logic [11:0] tick_cnt, next_tick_cnt;
  logic [13:0] sched_count, next_sched_count;
  logic [13:0] sched_interval, next_sched_interval;
  logic sched_fire, take_sched;
  assign sched_fire = sched_running && tick_cnt == TICK_LAST
                   && sched_count == 14'h0001;
  // counts 0.1 ms ticks; the first delay may differ from the interval
  always_comb begin
    next_sched_running = sched_running;
    next_tick_cnt = tick_cnt;
    next_sched_count = sched_count;
    next_sched_interval = sched_interval;
    next_sched_pending = (sched_pending & ~take_sched) | sched_fire;
    if (sched_running) begin
      next_tick_cnt = (tick_cnt == TICK_LAST) ? 12'h000 : tick_cnt + 12'h001;
      if (tick_cnt == TICK_LAST) begin
        next_sched_count = (sched_count == 14'h0001) ? sched_interval
                                                     : sched_count - 14'h0001;
      end
    end
    if (clr_ok && is_sched) begin
      next_sched_count = cmd.control[13:0];
      next_tick_cnt = 12'h000;
    end else if (msk_ok && is_sched) begin
      next_sched_running = cmd.control != SCHED_STOP;
      next_sched_interval = cmd.control[13:0];
      next_sched_count = cmd.control[13:0];
      next_tick_cnt = 12'h000;
    end
  end
  // timer stopped out of reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sched_running <= 1'b0;
      sched_pending <= 1'b0;
      tick_cnt <= 12'h000;
      sched_count <= 14'h0000;
      sched_interval <= 14'h0000;
    end else begin
      sched_running <= next_sched_running;
      sched_pending <= next_sched_pending;
      tick_cnt <= next_tick_cnt;
      sched_count <= next_sched_count;
      sched_interval <= next_sched_interval;
    end
  end

  // ----------------------------------------------------------------
  // pending records and masks
  // ----------------------------------------------------------------
  logic [5:0] take_io, take_hsc;
  logic pwr_pending, next_pwr_pending, take_pwr;
  // a new edge on an unmasked input always wins over a clear in the same cycle
  for (genvar i = 0; i < 6; i++) begin : g_rec
    logic io_clr, io_unmask, hsc_clr;
    assign io_clr = clr_ok && is_io && idx == 3'(i)
                 && cmd.control[0];
    assign io_unmask = msk_ok && is_io && idx == 3'(i)
                    && cmd.control == CTRL_UNMASK;
    assign hsc_clr = clr_ok && is_hsc && idx == 3'(i)
                  && cmd.control == CTRL_CLEAR;
    // latched even while a task runs or tasks are blocked
    assign next_io_pending[i] = (io_pending[i] & ~(io_clr | io_unmask
      | take_io[i])) | (edge_io[i] & ~io_mask[i]);
    assign next_io_mask[i] = (msk_ok && is_io && idx == 3'(i))
      ? cmd.control[0] : io_mask[i];
    assign next_hsc_pending[i] = (hsc_pending[i] & ~(hsc_clr | take_hsc[i]))
      | edge_hsc[i];
  end
  assign next_pwr_pending = (pwr_pending & ~take_pwr) | edge_pwr;
  // io masks come up set, so no io interrupt is recorded before an unmask
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_pending <= 6'h00;
      io_mask <= IO_MASK_RESET;
      hsc_pending <= 6'h00;
      pwr_pending <= 1'b0;
    end else begin
      io_pending <= next_io_pending;
      io_mask <= next_io_mask;
      hsc_pending <= next_hsc_pending;
      pwr_pending <= next_pwr_pending;
    end
  end

  // ----------------------------------------------------------------
  // global block and dispatch
  // ----------------------------------------------------------------
  ipc_task_t next_task;
  logic next_err, next_ack;
  // lowest set bit wins; bit 0 is the lowest input number
  function automatic logic [5:0] ipc_lowest(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int k = 5; k >= 0; k--) begin
      if (v[k]) begin
        r = 6'h00;
        r[k] = 1'b1;
      end
    end
    return r;
  endfunction : ipc_lowest
  function automatic logic [3:0] ipc_index(input logic [5:0] onehot);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 0; k < 6; k++) begin
      if (onehot[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : ipc_index
  // power-off is not subject to the block; one task runs at a time
  always_comb begin
    next_state = state;
    next_task = '{start: 1'b0, id: task_start.id};
    take_io = 6'h00;
    take_hsc = 6'h00;
    take_sched = 1'b0;
    take_pwr = 1'b0;
    next_blocked = blocked;
    if (cmd.valid && !in_task && cmd.op == OP_BLOCK) begin
      next_blocked = 1'b1;
    end else if (cmd.valid && !in_task && cmd.op == OP_UNBLOCK) begin
      next_blocked = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (pwr_pending) begin
          take_pwr = 1'b1;
          next_task = '{start: 1'b1, id: TASK_POWER_OFF};
        end else if (!blocked && io_pending != 6'h00) begin
          take_io = ipc_lowest(io_pending);
          next_task = '{start: 1'b1, id: TASK_IO_BASE + ipc_index(take_io)};
        end else if (!blocked && sched_pending) begin
          take_sched = 1'b1;
          next_task = '{start: 1'b1, id: TASK_SCHED};
        end else if (!blocked && hsc_pending != 6'h00) begin
          take_hsc = ipc_lowest(hsc_pending);
          next_task = '{start: 1'b1,
                        id: TASK_HSC_BASE + ipc_index(take_hsc)};
        end
        if (next_task.start) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (task_done) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // flag follows each command; valid operands clear it
    next_ack = cmd.valid;
    next_err = cmd.valid ? cmd_err : instruction_error_flag;
  end
  // dispatch state and command answer registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      blocked <= 1'b0;
      task_start <= '0;
      instruction_error_flag <= 1'b0;
      cmd_ack <= 1'b0;
    end else begin
      state <= next_state;
      blocked <= next_blocked;
      task_start <= next_task;
      instruction_error_flag <= next_err;
      cmd_ack <= next_ack;
    end
  end

  assign status = '{io_pending: io_pending, io_mask: io_mask,
                    hsc_pending: hsc_pending, sched_pending: sched_pending,
                    sched_running: sched_running, blocked: blocked,
                    in_task: in_task};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_clear_cmd;
    cmd.valid && cmd.op == OP_PENDING_CLEAR;
  endsequence
  sequence s_last_tick;
    sched_running && tick_cnt == TICK_LAST && sched_count == 14'h0001;
  endsequence

  a_bad_selector: assert property (s_clear_cmd ##0
    !(is_io || is_hsc || is_sched) |=> instruction_error_flag)
    else $error("undefined selector did not raise error");
  a_bad_io_ctrl: assert property (s_clear_cmd ##0
    (is_io || is_hsc) && !ctl01 |=> instruction_error_flag && cmd_ack)
    else $error("bad io or counter control accepted");
  a_sched_range: assert property (s_clear_cmd ##0 is_sched
    |=> instruction_error_flag == !$past(sched_ok))
    else $error("scheduled range check wrong");
  a_io_clear: assert property (s_clear_cmd ##0 is_io && ctl01
    && edge_io == 6'h00 |=> ((io_pending >> $past(idx)) & 6'h01)
    == (($past(io_pending) >> $past(idx)) & 6'h01
    & ~6'($past(cmd.control)) & ~($past(take_io) >> $past(idx))))
    else $error("io record clear or retain wrong");
  a_hsc_clear: assert property (s_clear_cmd ##0 is_hsc
    && cmd.control == CTRL_CLEAR && edge_hsc == 6'h00
    |=> ((hsc_pending >> $past(idx)) & 6'h01) == 6'h00)
    else $error("counter record not cleared");
  a_sched_fire: assert property (s_last_tick ##1 1'b1
    |-> sched_pending && sched_count == $past(sched_interval))
    else $error("scheduled interrupt not raised at end of delay");
  a_block_holds: assert property ($past(blocked) && task_start.start
    |-> task_start.id == TASK_POWER_OFF)
    else $error("task started while blocked");
  a_block_in_task: assert property (cmd.valid && cmd.op == OP_BLOCK
    && in_task |=> instruction_error_flag && blocked == $past(blocked))
    else $error("block inside task not rejected");
  a_latch_in_task: assert property (in_task ##0
    (edge_io & ~io_mask) != 6'h00
    |=> (io_pending & $past(edge_io & ~io_mask)) == $past(edge_io & ~io_mask))
    else $error("arrival during task dropped");
  a_lowest_first: assert property (task_start.start
    && task_start.id >= TASK_IO_BASE && task_start.id < TASK_HSC_BASE
    |-> ($past(io_pending) & 6'((7'h01 << (task_start.id - TASK_IO_BASE))
    - 7'h01)) == 6'h00)
    else $error("higher numbered input served first");

endmodule : ipc_top

// [tb/ipc_exec_model.sv]
// behavioural model of the instruction execution unit driving the block
`timescale 1ns/1ps
module ipc_exec_model
  import ipc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic done_en,
  input wire ipc_task_t task_start,
  output ipc_cmd_t cmd,
  output logic task_done
);
  int wait_n;

  initial begin
    cmd = '0;
    task_done = 1'b0;
    wait_n = -1;
  end

  // one instruction: valid for a single cycle, changed at falling edges
  task automatic issue(input ipc_op_t op, input logic [15:0] s, c);
    @(negedge clk);
    cmd = '{1'b1, op, s, c};
    @(negedge clk);
    cmd = '0;
  endtask : issue

  // task body runs a few cycles; done_en low keeps a task running
  always @(negedge clk) begin
    task_done <= 1'b0;
    if (reset) begin
      wait_n <= -1;
    end else if (task_start.start) begin
      wait_n <= 3;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end else if (wait_n == 0 && done_en) begin
      task_done <= 1'b1;
      wait_n <= -1;
    end
  end
  // records kept while blocked are served after the test sequence unblocks
endmodule : ipc_exec_model

// [tb/tb_top.sv]
// self-checking testbench of the interrupt pending control block
`timescale 1ns/1ps
module tb_top
  import ipc_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic done_en = 1'b1;
  logic [5:0] io_irq_pin = '0;
  logic [5:0] hsc_match_pin = '0;
  logic power_off_pin = 1'b0;
  ipc_cmd_t cmd;
  logic task_done;
  logic instruction_error_flag;
  logic cmd_ack;
  ipc_task_t task_start;
  ipc_status_t status;
  int n_fail = 0;
  int num_checks = 0;
  logic [3:0] q[$];
  logic [15:0] es[9];
  logic [15:0] ec[9];
  int t;

  always #20 clk = ~clk;

  ipc_top dut (.clk(clk), .reset(reset), .cmd(cmd),
    .io_irq_pin(io_irq_pin), .hsc_match_pin(hsc_match_pin),
    .power_off_pin(power_off_pin), .task_done(task_done),
    .instruction_error_flag(instruction_error_flag), .cmd_ack(cmd_ack),
    .task_start(task_start), .status(status));

  ipc_exec_model m (.clk(clk), .reset(reset), .done_en(done_en),
    .task_start(task_start), .cmd(cmd), .task_done(task_done));

  // ----------------------------------------------------------------
  // checking and driving tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // answer lands at the taking edge; ack stands only until the next one
  task automatic op(input ipc_op_t o, input logic [15:0] s, c,
                    input logic err);
    m.issue(o, s, c);
    check("ack", 16'(cmd_ack), 16'h0001);
    check("error flag", 16'(instruction_error_flag), 16'(err));
  endtask : op

  // pins are sampled through a synchroniser, so hold them a few cycles
  task automatic pins(input logic [5:0] io, hsc, input logic po);
    @(negedge clk);
    io_irq_pin = io;
    hsc_match_pin = hsc;
    power_off_pin = po;
    repeat (3) @(negedge clk);
    io_irq_pin = '0;
    hsc_match_pin = '0;
    power_off_pin = 1'b0;
    repeat (3) @(negedge clk);
  endtask : pins

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // task starts are collected once settled
  always @(negedge clk) begin
    if (task_start.start === 1'b1) begin
      q.push_back(task_start.id);
    end
  end

  // ----------------------------------------------------------------
  // watchdog: whole run is about 50150 cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    close_out();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    es = '{16'h0003, 16'h0065, 16'h006c, 16'h0010, 16'h0067, 16'h000b,
           16'h0004, 16'h0004, 16'h0004};
    ec = '{16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0002, 16'h0002,
           16'h0009, 16'h2710, 16'h000a};
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    check("mask", 16'(status.io_mask), 16'h003f);
    check("timer run", 16'(status.sched_running), 16'h0000);
    $display("test reset done");

    // bad selectors and control words; last entry is valid and stays off
    for (int i = 0; i < 9; i++) begin
      op(OP_PENDING_CLEAR, es[i], ec[i], i < 8);
    end
    @(negedge clk);
    check("ack low", 16'(cmd_ack), 16'h0000);
    check("timer run", 16'(status.sched_running), 16'h0000);
    $display("test errors done");

    // unmask all inputs, then block from main code
    for (int s = 102; s <= 107; s++) begin
      op(OP_MASK_SET, 16'(s), 16'h0000, 1'b0);
    end
    op(OP_BLOCK, 16'h0000, 16'h0000, 1'b0);
    check("blocked", 16'(status.blocked), 16'h0001);
    pins(6'b001010, 6'b000100, 1'b0);
    check("io pend", 16'(status.io_pending), 16'h000a);
    check("hsc pend", 16'(status.hsc_pending), 16'h0004);
    check("starts", 16'(q.size()), 16'h0000);
    op(OP_PENDING_CLEAR, 16'h0067, 16'h0000, 1'b0);
    check("io retain", 16'(status.io_pending), 16'h000a);
    op(OP_PENDING_CLEAR, 16'h0067, 16'h0001, 1'b0);
    check("io clear", 16'(status.io_pending), 16'h0008);
    op(OP_PENDING_CLEAR, 16'h000c, 16'h0000, 1'b0);
    check("hsc retain", 16'(status.hsc_pending), 16'h0004);
    op(OP_PENDING_CLEAR, 16'h000c, 16'h0001, 1'b0);
    check("hsc clear", 16'(status.hsc_pending), 16'h0000);
    $display("test records done");

    // power-off still runs while blocked; arrivals during it are kept
    done_en = 1'b0;
    pins(6'b000010, 6'b000000, 1'b1);
    check("pwr n", 16'(q.size()), 16'h0001);
    check("pwr id", 16'(q[0]), 16'h000f);
    check("in task", 16'(status.in_task), 16'h0001);
    op(OP_BLOCK, 16'h0000, 16'h0000, 1'b1);
    pins(6'b000001, 6'b000000, 1'b0);
    check("io latched", 16'(status.io_pending), 16'h000b);
    done_en = 1'b1;
    repeat (8) @(negedge clk);
    check("task end", 16'(status.in_task), 16'h0000);
    check("still blk", 16'(status.blocked), 16'h0001);
    check("starts", 16'(q.size()), 16'h0001);
    q.delete();
    op(OP_MASK_SET, 16'h0066, 16'h0000, 1'b0);
    check("unmask", 16'(status.io_pending), 16'h000a);
    $display("test power-off done");

    // unblock: kept records served lowest number first
    op(OP_UNBLOCK, 16'h0000, 16'h0000, 1'b0);
    repeat (30) @(negedge clk);
    check("n served", 16'(q.size()), 16'h0002);
    check("first id", 16'(q[0]), 16'h0003);
    check("second id", 16'(q[1]), 16'h0005);
    q.delete();
    $display("test priority done");

    // masked input ignored; counter comparison runs its own task
    op(OP_MASK_SET, 16'h0066, 16'h0001, 1'b0);
    check("mask", 16'(status.io_mask), 16'h0001);
    pins(6'b000001, 6'b100000, 1'b0);
    repeat (8) @(negedge clk);
    check("masked", 16'(status.io_pending), 16'h0000);
    check("hsc n", 16'(q.size()), 16'h0001);
    check("hsc id", 16'(q[0]), 16'h000d);
    op(OP_NONE, 16'h0066, 16'h0000, 1'b1);
    op(OP_MASK_SET, 16'h000a, 16'h0000, 1'b1);
    op(OP_MASK_SET, 16'h0067, 16'h0002, 1'b1);
    check("mask kept", 16'(status.io_mask), 16'h0001);
    q.delete();
    $display("test masks done");

    // scheduled timer: 10 units to the first interrupt, task 1
    op(OP_MASK_SET, SEL_SCHED, 16'h000a, 1'b0);
    check("timer run", 16'(status.sched_running), 16'h0001);
    t = 0;
    while (q.size() == 0 && t < 30000) begin
      @(negedge clk);
      t++;
    end
    check("sched delay", 16'(t > 10 * SCHED_UNIT_CYCLES - 10 &&
      t < 10 * SCHED_UNIT_CYCLES + 10), 16'h0001);
    check("sched id", 16'(q[0]), 16'h0001);
    // next firing while blocked stays recorded until the unblock
    repeat (8) @(negedge clk);
    op(OP_BLOCK, 16'h0000, 16'h0000, 1'b0);
    q.delete();
    t = 0;
    while (status.sched_pending !== 1'b1 && t < 30000) begin
      @(negedge clk);
      t++;
    end
    repeat (4) @(negedge clk);
    check("sched kept", 16'(status.sched_pending), 16'h0001);
    check("sched held", 16'(q.size()), 16'h0000);
    op(OP_UNBLOCK, 16'h0000, 16'h0000, 1'b0);
    repeat (4) @(negedge clk);
    check("sched n", 16'(q.size()), 16'h0001);
    check("sched late", 16'(q[0]), 16'h0001);
    check("sched taken", 16'(status.sched_pending), 16'h0000);
    op(OP_MASK_SET, SEL_SCHED, 16'h0000, 1'b0);
    check("timer stop", 16'(status.sched_running), 16'h0000);
    $display("test scheduled done");
    close_out();
  end
endmodule : tb_top
